// ===== shared/mfr_info_consts.svh
// Command codes, framing bytes and field sizes of the identification stores.
`ifndef MFR_INFO_CONSTS_SVH
`define MFR_INFO_CONSTS_SVH

`define MFR_CMD_IDENTITY 8'h99
`define MFR_CMD_MODEL 8'h9a
`define MFR_CMD_REVISION 8'h9b
`define MFR_CMD_SERIAL 8'h9e

`define MFR_IDX_IDENTITY 2'h0
`define MFR_IDX_MODEL 2'h1
`define MFR_IDX_REVISION 2'h2
`define MFR_IDX_SERIAL 2'h3

`define MFR_STORE_BITS 24
`define MFR_BLOCK_COUNT 8'h03
`define MFR_READ_FILL 8'hff
`define MFR_RESET_STORE 24'h000000

`endif

// ===== shared/mfr_info_pkg.sv
// Types shared by the identification store block and its bench.
package mfr_info_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_COUNT,
		ST_WR_DATA,
		ST_WR_DROP,
		ST_RD
	} mfr_phase_type;

	// One transaction boundary from the PMBus transaction engine.
	typedef struct packed {
		logic start;
		logic stop;
		logic isRead;
		logic [7:0] cmd;
	} mfr_txn_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mfr_byte_type;

	// Index 0 identity, 1 model, 2 revision, 3 serial.
	typedef logic [3:0][23:0] mfr_image_type;

	typedef struct packed {
		logic valid;
		mfr_image_type image;
	} mfr_load_type;

	typedef struct packed {
		mfr_phase_type phase;
		logic [1:0] sel;
		logic [2:0] cnt;
		logic [23:0] shadow;
		mfr_image_type image;
		mfr_byte_type rdOut;
		logic cmdHit;
		logic protoErr;
		logic commitPulse;
		logic [23:0] digest;
	} mfr_state_type;

endpackage

// ===== rtl/mfr_info_store.sv
// Nonvolatile-backed manufacturer identification stores with block access.
`timescale 1ns/1ns
`include "mfr_info_consts.svh"

module mfr_info_store (
	input wire logic clk,
	input wire logic rst_n,
	input wire mfr_info_pkg::mfr_load_type nvmLoad,
	input wire mfr_info_pkg::mfr_txn_type txn,
	input wire mfr_info_pkg::mfr_byte_type wrByte,
	input wire logic rdReq,
	output mfr_info_pkg::mfr_byte_type rdByte,
	output logic cmdHit,
	output logic protoErr,
	output logic commitPulse,
	output mfr_info_pkg::mfr_image_type storeImage,
	output logic [23:0] storedConfigDigest
);
	import mfr_info_pkg::*;

	mfr_state_type s;
	mfr_state_type next_s;

	// Maps a command code to a store index; bit 2 says the code is ours.
	function automatic logic [2:0] cmdDecode(input logic [7:0] cmd);
		case (cmd)
			`MFR_CMD_IDENTITY: cmdDecode = {1'b1, `MFR_IDX_IDENTITY};
			`MFR_CMD_MODEL: cmdDecode = {1'b1, `MFR_IDX_MODEL};
			`MFR_CMD_REVISION: cmdDecode = {1'b1, `MFR_IDX_REVISION};
			`MFR_CMD_SERIAL: cmdDecode = {1'b1, `MFR_IDX_SERIAL};
			default: cmdDecode = 3'h0;
		endcase
	endfunction

	// Picks one byte of a store, byte 0 being the least significant.
	function automatic logic [7:0] byteOf(input logic [23:0] w,
		input logic [1:0] i);
		case (i)
			2'h0: byteOf = w[7:0];
			2'h1: byteOf = w[15:8];
			default: byteOf = w[23:16];
		endcase
	endfunction

	// Command code of each store index, the inverse of cmdDecode. The
	// checks below use it so that a swapped decode entry cannot hide.
	function automatic logic [7:0] codeOf(input logic [1:0] idx);
		case (idx)
			`MFR_IDX_IDENTITY: codeOf = `MFR_CMD_IDENTITY;
			`MFR_IDX_MODEL: codeOf = `MFR_CMD_MODEL;
			`MFR_IDX_REVISION: codeOf = `MFR_CMD_REVISION;
			default: codeOf = `MFR_CMD_SERIAL;
		endcase
	endfunction

	// The rotations keep the digest a one-to-one function of each store
	// alone, so a new serial number always gives a new digest.
	function automatic logic [23:0] digestOf(input mfr_image_type img);
		digestOf = img[0] ^ {img[1][15:0], img[1][23:16]} ^
			{img[2][7:0], img[2][23:8]} ^ img[3];
	endfunction

	logic [2:0] decoded;
	assign decoded = cmdDecode(txn.cmd);

	// Next-state logic. The nonvolatile load outranks any transaction so
	// that power-up content is never half overwritten by an early access.
	always_comb begin
		next_s = s;
		next_s.rdOut.valid = 1'b0;
		next_s.protoErr = 1'b0;
		next_s.commitPulse = 1'b0;
		next_s.digest = digestOf(s.image);
		if (nvmLoad.valid) begin
			next_s.image = nvmLoad.image;
			next_s.phase = ST_IDLE;
		end else if (txn.start) begin
			// No phase input exists: every access hits the single copy.
			next_s.cmdHit = decoded[2];
			next_s.sel = decoded[1:0];
			next_s.cnt = 3'h0;
			if (!decoded[2]) begin
				next_s.phase = ST_IDLE;
			end else if (txn.isRead) begin
				next_s.phase = ST_RD;
			end else begin
				next_s.phase = ST_WR_COUNT;
			end
		end else if (txn.stop) begin
			// A write that stops short is dropped whole, never half applied.
			if (s.phase == ST_WR_DATA || s.phase == ST_WR_COUNT) begin
				next_s.protoErr = 1'b1;
			end
			next_s.phase = ST_IDLE;
		end else begin
			case (s.phase)
				ST_WR_COUNT: begin
					if (wrByte.valid) begin
						if (wrByte.data == `MFR_BLOCK_COUNT) begin
							next_s.phase = ST_WR_DATA;
						end else begin
							next_s.protoErr = 1'b1;
							next_s.phase = ST_WR_DROP;
						end
					end
				end
				ST_WR_DATA: begin
					if (wrByte.valid) begin
						// Raw bytes go in unchanged, low byte first.
						case (s.cnt)
							3'h0: next_s.shadow[7:0] = wrByte.data;
							3'h1: next_s.shadow[15:8] = wrByte.data;
							default: next_s.shadow[23:16] = wrByte.data;
						endcase
						if (s.cnt == 3'h2) begin
							next_s.image[s.sel] = {wrByte.data, s.shadow[15:0]};
							next_s.commitPulse = 1'b1;
							next_s.phase = ST_WR_DROP;
						end else begin
							next_s.cnt = s.cnt + 3'h1;
						end
					end
				end
				ST_WR_DROP: begin
					// Bytes beyond the block are refused and flagged.
					if (wrByte.valid) begin
						next_s.protoErr = 1'b1;
					end
				end
				ST_RD: begin
					if (rdReq) begin
						next_s.rdOut.valid = 1'b1;
						case (s.cnt)
							3'h0: next_s.rdOut.data = `MFR_BLOCK_COUNT;
							3'h1, 3'h2, 3'h3: begin
								next_s.rdOut.data = byteOf(s.image[s.sel],
									2'(s.cnt - 3'h1));
							end
							default: next_s.rdOut.data = `MFR_READ_FILL;
						endcase
						if (s.cnt != 3'h4) begin
							next_s.cnt = s.cnt + 3'h1;
						end
					end
				end
				default: begin
					next_s.phase = ST_IDLE;
				end
			endcase
		end
	end

	// State register; the stores clear on reset until the image arrives.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// All outputs are fields of the state register.
	assign rdByte = s.rdOut;
	assign cmdHit = s.cmdHit;
	assign protoErr = s.protoErr;
	assign commitPulse = s.commitPulse;
	assign storeImage = s.image;
	assign storedConfigDigest = s.digest;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic quiet;
	assign quiet = !nvmLoad.valid && !txn.start && !txn.stop;

	a_load_sets_image: assert property (
		nvmLoad.valid |=> s.image == $past(nvmLoad.image))
		else $error("Stores did not take the nonvolatile image.");

	a_only_writes_change: assert property (
		!$stable(s.image) |-> $past(nvmLoad.valid) || s.commitPulse)
		else $error("A store changed without a load or block write.");

	a_identity_commit: assert property (
		s.commitPulse && s.sel == `MFR_IDX_IDENTITY |->
		s.image[0][23:16] == $past(wrByte.data))
		else $error("Identity store missed its top byte.");

	a_model_commit: assert property (
		s.commitPulse && s.sel == `MFR_IDX_MODEL |->
		s.image[1] == {$past(wrByte.data), $past(s.shadow[15:0])})
		else $error("Model store did not take the written value.");

	a_revision_commit: assert property (
		s.commitPulse && s.sel == `MFR_IDX_REVISION |->
		s.image[2] == {$past(wrByte.data), $past(s.shadow[15:0])})
		else $error("Revision store did not take the written value.");

	a_serial_commit: assert property (
		s.commitPulse && s.sel == `MFR_IDX_SERIAL |->
		s.image[3] == {$past(wrByte.data), $past(s.shadow[15:0])})
		else $error("Serial store did not take the written value.");

	a_read_count_first: assert property (
		txn.start && txn.isRead && decoded[2] && !nvmLoad.valid ##1
		(rdReq && quiet) |=> s.rdOut.valid &&
		s.rdOut.data == `MFR_BLOCK_COUNT)
		else $error("Block read did not open with a count of three.");

	a_read_low_byte: assert property (
		s.phase == ST_RD && s.cnt == 3'h1 && rdReq && quiet |=>
		s.rdOut.valid && s.rdOut.data == byteOf($past(s.image[s.sel]), 2'h0))
		else $error("First data byte is not the low byte of the store.");

	a_bad_count_flag: assert property (
		s.phase == ST_WR_COUNT && wrByte.valid && quiet &&
		wrByte.data != `MFR_BLOCK_COUNT |=> s.protoErr && !s.commitPulse)
		else $error("Wrong byte count was not refused.");

	a_digest_serial: assert property (
		!$stable(s.image[3]) && $stable(s.image[2:0]) |=>
		!$stable(s.digest))
		else $error("Digest ignored a new serial number.");

	a_unknown_cmd_quiet: assert property (
		txn.start && !decoded[2] && !nvmLoad.valid |=>
		!s.cmdHit && s.phase == ST_IDLE)
		else $error("An unknown command code was not refused.");

	a_short_write_flag: assert property (
		txn.stop && !txn.start && !nvmLoad.valid &&
		(s.phase == ST_WR_COUNT || s.phase == ST_WR_DATA) |=>
		s.protoErr && !s.commitPulse && $stable(s.image))
		else $error("A short write was not dropped and flagged.");

	a_load_aborts: assert property (
		nvmLoad.valid |=> s.phase == ST_IDLE && !s.commitPulse)
		else $error("A nonvolatile load did not end the transfer.");

	a_commit_single: assert property (
		s.commitPulse |=> !s.commitPulse)
		else $error("One block write committed twice.");

	a_count_accept: assert property (
		s.phase == ST_WR_COUNT && wrByte.valid && quiet &&
		wrByte.data == `MFR_BLOCK_COUNT |=>
		s.phase == ST_WR_DATA && !s.protoErr)
		else $error("A byte count of three was not accepted.");

	a_extra_byte_flag: assert property (
		s.phase == ST_WR_DROP && wrByte.valid && quiet |=> s.protoErr)
		else $error("A byte beyond the block was not flagged.");

	a_read_answer: assert property (
		s.phase == ST_RD && rdReq && quiet |=> s.rdOut.valid)
		else $error("A read byte request went unanswered.");

	a_read_unasked: assert property (
		!rdReq |=> !s.rdOut.valid)
		else $error("A read byte appeared without a request.");

	a_read_mid_byte: assert property (
		s.phase == ST_RD && s.cnt == 3'h2 && rdReq && quiet |=>
		s.rdOut.data == $past(s.image[s.sel][15:8]))
		else $error("Second read byte is not bits 15 to 8.");

	a_read_top_byte: assert property (
		s.phase == ST_RD && s.cnt == 3'h3 && rdReq && quiet |=>
		s.rdOut.data == $past(s.image[s.sel][23:16]))
		else $error("Third read byte is not bits 23 to 16.");

	a_read_fill: assert property (
		s.phase == ST_RD && s.cnt == 3'h4 && rdReq && quiet |=>
		s.rdOut.data == `MFR_READ_FILL)
		else $error("A read past the block did not return fill.");

	// Per-store checks: each code reaches only its own store, and a
	// commit to one store leaves the other three as they were.
	for (genvar g = 0; g < 4; g++) begin : g_store
		a_code_selects: assert property (
			txn.start && txn.cmd == codeOf(2'(g)) && !nvmLoad.valid |=>
			s.cmdHit && s.sel == 2'(g))
			else $error("A command code did not select its own store.");

		a_store_isolated: assert property (
			s.commitPulse && s.sel != 2'(g) |->
			s.image[g] == $past(s.image[g]))
			else $error("A block write disturbed another store.");
	end

	c_block_write: cover property (s.commitPulse);
	c_block_read: cover property (
		s.rdOut.valid && s.cnt == 3'h4 && s.phase == ST_RD);
	c_nvm_load: cover property (nvmLoad.valid ##2 !$stable(s.digest));
	c_proto_error: cover property (s.protoErr);

endmodule // mfr_info_store

// ===== verif/mfr_host.sv
// Behavioural PMBus host that issues block writes and block reads.
`timescale 1ns/1ns
`include "mfr_info_consts.svh"
module mfr_host (
	input wire logic clk,
	input wire mfr_info_pkg::mfr_byte_type rdByte,
	input wire logic commitPulse,
	input wire logic protoErr,
	output mfr_info_pkg::mfr_txn_type txn,
	output mfr_info_pkg::mfr_byte_type wrByte,
	output logic rdReq
);
	import mfr_info_pkg::*;

	// The host is idle until a task is called.
	initial begin
		txn = '0;
		wrByte = '0;
		rdReq = 1'b0;
	end

	// Start, count, three bytes low first, then stop; flags are sampled
	// the cycle after the last byte, when a commit must show.
	task automatic blkWrite(input logic [7:0] cmd, input logic [23:0] val,
		input logic [7:0] cnt, output logic [1:0] flags);
		logic [31:0] frame;
		frame = {val, cnt};
		@(negedge clk);
		txn = '{1'b1, 1'b0, 1'b0, cmd};
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			txn.start = 1'b0;
			wrByte = '{1'b1, frame[8*i +: 8]};
		end
		@(negedge clk);
		flags = {commitPulse, protoErr};
		// A released data line must not keep showing the last byte.
		wrByte = '{1'b0, ~wrByte.data};
		txn.stop = 1'b1;
		@(negedge clk);
		txn.stop = 1'b0;
	endtask

	// Five back-to-back byte requests; an unanswered byte comes back unknown.
	task automatic blkRead(input logic [7:0] cmd, output logic [39:0] got);
		logic [7:0] b;
		@(negedge clk);
		txn = '{1'b1, 1'b0, 1'b1, cmd};
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			txn.start = 1'b0;
			b = (rdByte.valid === 1'b1) ? rdByte.data : 8'hxx;
			if (i > 0) got = {b, got[39:8]};
			rdReq = (i < 5);
		end
		txn.stop = 1'b1;
		@(negedge clk);
		txn.stop = 1'b0;
	endtask

	// A write cut off after two data bytes; flags are sampled the cycle
	// after the stop, where the refusal must show.
	task automatic blkShort(input logic [7:0] cmd, input logic [23:0] val,
		output logic [1:0] flags);
		logic [31:0] frame;
		frame = {val, `MFR_BLOCK_COUNT};
		@(negedge clk);
		txn = '{1'b1, 1'b0, 1'b0, cmd};
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			txn.start = 1'b0;
			wrByte = '{1'b1, frame[8*i +: 8]};
		end
		@(negedge clk);
		wrByte = '{1'b0, ~wrByte.data};
		txn.stop = 1'b1;
		@(negedge clk);
		txn.stop = 1'b0;
		flags = {commitPulse, protoErr};
	endtask
endmodule // mfr_host

// ===== verif/tb.sv
// Self-checking bench for the identification store block.
`timescale 1ns/1ns
`include "mfr_info_consts.svh"
module tb;
	import mfr_info_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mfr_load_type nvmLoad = '0;
	mfr_txn_type txn;
	mfr_byte_type wrByte;
	mfr_byte_type rdByte;
	logic rdReq, cmdHit, protoErr, commitPulse;
	mfr_image_type storeImage, expImg;
	logic [23:0] storedConfigDigest, val;
	logic [39:0] got;
	logic [1:0] flags;
	logic [7:0] cmds [4] = '{`MFR_CMD_IDENTITY, `MFR_CMD_MODEL,
		`MFR_CMD_REVISION, `MFR_CMD_SERIAL};
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int k;

	// Digest of the chosen form: identity, model turned left by a byte,
	// revision turned right by a byte and serial, folded by XOR.
	function automatic logic [23:0] expDigest(input mfr_image_type img);
		expDigest = img[0] ^ {img[1][15:0], img[1][23:16]} ^
			{img[2][7:0], img[2][23:8]} ^ img[3];
	endfunction

	// A block read gives the count, the store low byte first, then fill.
	function automatic logic [39:0] expRead(input logic [23:0] v);
		expRead = {`MFR_READ_FILL, v, `MFR_BLOCK_COUNT};
	endfunction

	// Free-running 25 MHz clock.
	always #20 clk = ~clk;

	mfr_info_store u_dut (.clk(clk), .rst_n(rst_n), .nvmLoad(nvmLoad),
		.txn(txn), .wrByte(wrByte), .rdReq(rdReq), .rdByte(rdByte),
		.cmdHit(cmdHit), .protoErr(protoErr), .commitPulse(commitPulse),
		.storeImage(storeImage), .storedConfigDigest(storedConfigDigest));

	mfr_host u_host (.clk(clk), .rdByte(rdByte), .commitPulse(commitPulse),
		.protoErr(protoErr), .txn(txn), .wrByte(wrByte), .rdReq(rdReq));

	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// A hang counts as a mismatch and ends the whole run after 3000 cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			tally_and_finish();
		end
	end

	// Main sequence: load, random block traffic, refusals, second reset.
	initial begin
		void'($urandom(32'h968d));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check(storeImage, '0);
		for (int i = 0; i < 4; i++) expImg[i] = 24'($urandom);
		nvmLoad = '{1'b1, expImg};
		@(negedge clk);
		nvmLoad.valid = 1'b0;
		check(storeImage, expImg);
		@(negedge clk);
		for (int n = 0; n < 14; n++) begin
			k = (n < 4) ? n : $urandom_range(3);
			val = (n < 2) ? {24{n[0]}} : 24'($urandom);
			u_host.blkWrite(cmds[k], val, `MFR_BLOCK_COUNT, flags);
			check(flags, 2'b10);
			expImg[k] = val;
			u_host.blkRead(cmds[k], got);
			check(got, expRead(val));
			check(storeImage, expImg);
			check(storedConfigDigest, expDigest(expImg));
		end
		// A wrong count and an unknown code must leave every store alone.
		// Bytes after a refused count keep the error flag raised.
		u_host.blkWrite(cmds[1], 24'($urandom), 8'h04, flags);
		check(flags, 2'b01);
		u_host.blkWrite(8'h9c, 24'($urandom), `MFR_BLOCK_COUNT, flags);
		check({cmdHit, flags}, 3'b000);
		check(storeImage, expImg);
		u_host.blkShort(cmds[2], 24'($urandom), flags);
		check(flags, 2'b01);
		check(storeImage, expImg);
		rst_n = 1'b0;
		@(negedge clk);
		check(storeImage, '0);
		check(storedConfigDigest, '0);
		// Second release: the stores must come back from a fresh image.
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) expImg[i] = 24'($urandom);
		nvmLoad = '{1'b1, expImg};
		@(negedge clk);
		nvmLoad.valid = 1'b0;
		check(storeImage, expImg);
		@(negedge clk);
		check(storedConfigDigest, expDigest(expImg));
		u_host.blkRead(cmds[3], got);
		check(got, expRead(expImg[3]));
		tally_and_finish();
	end
endmodule // tb
